// ===== hdl/align_if.sv
// Carrier between the sequencer and the byte aligner.
// Assumes both ends run combinationally within one clock.
`timescale 1ns/1ps
interface align_if;
  import lsu_align_pkg::*;

  op_t                 op;
  logic [LANE_W-1:0]   lane;
  logic                mode64;
  logic [DWORD_W-1:0]  target_value;
  logic [WORD_W-1:0]   mem_word;
  logic [DWORD_W-1:0]  load_value;
  logic [WORD_W-1:0]   store_data;
  logic [LANES-1:0]    store_be;

  modport seq   (output op, lane, mode64, target_value, mem_word,
                 input load_value, store_data, store_be);
  modport align (input op, lane, mode64, target_value, mem_word,
                 output load_value, store_data, store_be);
endinterface

// ===== hdl/byte_aligner.sv
// Combinational shift, merge and byte-enable logic for word accesses.
// Assumes lane 0 is the lowest byte address of a little-endian word.
`timescale 1ns/1ps
module byte_aligner
  import lsu_align_pkg::*;
(
  align_if.align a
);

  logic [WORD_W-1:0] shifted;
  logic [WORD_W-1:0] merged;
  logic [LANES-1:0]  keep_mem;
  logic [4:0]        sh_l;
  logic [4:0]        sh_r;

  // Shift amounts in bits, eight per lane, for left and right partial forms
  assign sh_l = {2'(LANES - 1) - a.lane, 3'h0};
  assign sh_r = {1'b0, a.lane, 2'h0} << 1;

  // Shifted memory word and lanes it covers
  always_comb begin
    unique case (a.op)
      load_word_left_partial_op: begin
        shifted  = a.mem_word << sh_l;
        keep_mem = BE_WORD << (2'(LANES - 1) - a.lane);
      end
      load_word_right_partial_op: begin
        shifted  = a.mem_word >> sh_r;
        keep_mem = BE_WORD >> a.lane;
      end
      default: begin
        shifted  = a.mem_word;
        keep_mem = BE_WORD;
      end
    endcase
  end

  // Merge with the destination bytes left uncovered
  for (genvar i = 0; i < LANES; i++) begin : g_merge
    assign merged[i*BYTE_W +: BYTE_W] = keep_mem[i] ? shifted[i*BYTE_W +: BYTE_W]
                                        : a.target_value[i*BYTE_W +: BYTE_W];
  end

  // Sign-extend in 64-bit mode, upper half zero otherwise
  assign a.load_value = a.mode64 ? {{WORD_W{merged[SIGN_BIT]}}, merged}
                                 : {WORD_ZERO, merged};

  // Store data placement and byte enables
  always_comb begin
    a.store_data = a.target_value[WORD_W-1:0];
    a.store_be   = BE_NONE;
    unique case (a.op)
      store_byte_op: begin
        a.store_data = {LANES{a.target_value[BYTE_W-1:0]}};
        a.store_be   = BE_BYTE << a.lane;
      end
      store_halfword_op: begin
        a.store_data = {2{a.target_value[HALF_W-1:0]}};
        a.store_be   = BE_HALF << {a.lane[1], 1'b0};
      end
      store_word_op: begin
        a.store_be   = BE_WORD;
      end
      store_word_left_partial_op: begin
        a.store_data = a.target_value[WORD_W-1:0] >> sh_l;
        a.store_be   = BE_WORD >> (2'(LANES - 1) - a.lane);
      end
      store_word_right_partial_op: begin
        a.store_data = a.target_value[WORD_W-1:0] << sh_r;
        a.store_be   = BE_WORD << a.lane;
      end
      default: begin
        a.store_be   = BE_NONE;
      end
    endcase
  end

endmodule

// ===== hdl/load_store_word_align_unit.sv
// Load/store word alignment unit: address, memory request and writeback.
// Assumes the memory path answers each request with one mem_ack pulse.
//
// Overview of operation
// - Address is base plus sign-extended sixteen-bit offset.
// - Word load returns the addressed 32-bit word to the target.
// - In 64-bit mode the loaded word is sign-extended to 64 bits.
// - Left partial load shifts the addressed byte into the top lane.
// - Right partial load shifts the addressed byte into the bottom lane.
// - Partial loads merge shifted bytes with uncovered target bytes.
// - Byte store writes the target's low byte to one addressed lane.
// - Halfword store writes the target's low halfword to addressed half.
// - Left partial store shifts target right, top byte to addressed lane.
// - Left partial store writes only lanes zero up to the addressed lane.
// - Right partial store shifts target left, writes addressed lane upward.
`timescale 1ns/1ps
module load_store_word_align_unit
  import lsu_align_pkg::*;
(
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  input  wire logic                req_valid,
  input  wire op_t                 req_op,
  input  wire logic                mode64,
  input  wire logic [DWORD_W-1:0]  base_value,
  input  wire logic [OFFSET_W-1:0] offset,
  input  wire logic [DWORD_W-1:0]  target_register,
  output logic                     req_ready,
  output logic                     mem_req,
  output logic                     mem_we,
  output logic [DWORD_W-1:0]       mem_addr,
  output logic [LANES-1:0]         mem_be,
  output logic [WORD_W-1:0]        mem_wdata,
  input  wire logic [WORD_W-1:0]   mem_rdata,
  input  wire logic                mem_ack,
  output logic                     wb_valid,
  output logic [DWORD_W-1:0]       wb_data,
  output logic                     done
);

  state_t             state_q,  state_d;
  op_t                op_q,     op_d;
  logic               mode_q,   mode_d;
  logic [DWORD_W-1:0] tgt_q,    tgt_d;
  logic [DWORD_W-1:0] addr_q,   addr_d;
  logic               ready_q,  ready_d;
  logic               req_q,    req_d;
  logic               we_q,     we_d;
  logic [LANES-1:0]   be_q,     be_d;
  logic [WORD_W-1:0]  wdata_q,  wdata_d;
  logic               wbv_q,    wbv_d;
  logic [DWORD_W-1:0] wbd_q,    wbd_d;
  logic               done_q,   done_d;
  logic               is_store;
  logic [DWORD_W-1:0] virt_addr;
  logic               take;
  logic               answer;

  align_if al ();

  byte_aligner u_align (
    .a (al.align)
  );

  // Aligner works on the latched request
  assign al.op           = op_q;
  assign al.lane         = addr_q[LANE_W-1:0];
  assign al.mode64       = mode_q;
  assign al.target_value = tgt_q;
  assign al.mem_word     = mem_rdata;

  // Virtual address and access direction
  assign virt_addr = base_value + {{(DWORD_W-OFFSET_W){offset[OFFSET_W-1]}}, offset};
  assign is_store  = (op_q == store_byte_op) || (op_q == store_halfword_op) ||
                     (op_q == store_word_op) || (op_q == store_word_left_partial_op) ||
                     (op_q == store_word_right_partial_op);

  // Request taken while idle
  assign take = (state_q == st_idle) && req_valid && ready_q;

  // Memory answer while waiting
  assign answer = (state_q == st_wait) && mem_ack;

  // Control next state: sequencing, ready and completion
  always_comb begin
    state_d = state_q;
    ready_d = ready_q;
    done_d  = 1'b0;
    unique case (state_q)
      st_idle: begin
        if (take) begin
          ready_d = 1'b0;
          state_d = st_issue;
        end
      end
      st_issue: begin
        state_d = st_wait;
      end
      st_wait: begin
        if (answer) begin
          done_d  = 1'b1;
          ready_d = 1'b1;
          state_d = st_idle;
        end
      end
      default: begin
        ready_d = 1'b1;
        state_d = st_idle;
      end
    endcase
  end

  // Control registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= st_idle;
      ready_q <= 1'b1;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      ready_q <= ready_d;
      done_q  <= done_d;
    end
  end

  // Request capture next state, loaded only when taken
  always_comb begin
    op_d   = op_q;
    mode_d = mode_q;
    tgt_d  = tgt_q;
    addr_d = addr_q;
    if (take) begin
      op_d   = req_op;
      mode_d = mode64;
      tgt_d  = target_register;
      addr_d = virt_addr;
    end
  end

  // Request capture registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_q   <= load_word_op;
      mode_q <= 1'b0;
      tgt_q  <= DWORD_ZERO;
      addr_q <= DWORD_ZERO;
    end else begin
      op_q   <= op_d;
      mode_q <= mode_d;
      tgt_q  <= tgt_d;
      addr_q <= addr_d;
    end
  end

  // Memory request next state, held until the acknowledge
  always_comb begin
    req_d   = req_q;
    we_d    = we_q;
    be_d    = be_q;
    wdata_d = wdata_q;
    if (state_q == st_issue) begin
      req_d   = 1'b1;
      we_d    = is_store;
      be_d    = is_store ? al.store_be : BE_WORD;
      wdata_d = al.store_data;
    end else if (answer) begin
      req_d   = 1'b0;
      we_d    = 1'b0;
      be_d    = BE_NONE;
    end
  end

  // Memory request registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_q   <= 1'b0;
      we_q    <= 1'b0;
      be_q    <= BE_NONE;
      wdata_q <= WORD_ZERO;
    end else begin
      req_q   <= req_d;
      we_q    <= we_d;
      be_q    <= be_d;
      wdata_q <= wdata_d;
    end
  end

  // Writeback next state, loads only; stores leave the data alone
  always_comb begin
    wbv_d = 1'b0;
    wbd_d = wbd_q;
    if (answer && !is_store) begin
      wbv_d = 1'b1;
      wbd_d = al.load_value;
    end
  end

  // Writeback registers
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wbv_q <= 1'b0;
      wbd_q <= DWORD_ZERO;
    end else begin
      wbv_q <= wbv_d;
      wbd_q <= wbd_d;
    end
  end

  // Outputs straight from flops
  assign req_ready = ready_q;
  assign mem_req   = req_q;
  assign mem_we    = we_q;
  assign mem_addr  = addr_q;
  assign mem_be    = be_q;
  assign mem_wdata = wdata_q;
  assign wb_valid  = wbv_q;
  assign wb_data   = wbd_q;
  assign done      = done_q;

endmodule

// ===== hdl/lsu_align_pkg.sv
// Shared types and constants of the load/store alignment unit.
// Assumes a little-endian, 32-bit wide data memory path.
package lsu_align_pkg;

  localparam int unsigned DWORD_W  = 64;
  localparam int unsigned WORD_W   = 32;
  localparam int unsigned HALF_W   = 16;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned OFFSET_W = 16;
  localparam int unsigned LANES    = 4;
  localparam int unsigned LANE_W   = 2;
  localparam int unsigned SIGN_BIT = 31;

  // Byte-enable patterns
  localparam logic [3:0] BE_NONE = 4'h0;
  localparam logic [3:0] BE_BYTE = 4'h1;
  localparam logic [3:0] BE_HALF = 4'h3;
  localparam logic [3:0] BE_WORD = 4'hf;

  // Reset values
  localparam logic [DWORD_W-1:0] DWORD_ZERO = 64'h0000_0000_0000_0000;
  localparam logic [WORD_W-1:0]  WORD_ZERO  = 32'h0000_0000;
  localparam logic [LANE_W-1:0]  LANE_ZERO  = 2'h0;

  // Operations handled by the unit
  typedef enum logic [2:0] {
    load_word_op,
    load_word_left_partial_op,
    load_word_right_partial_op,
    store_byte_op,
    store_halfword_op,
    store_word_op,
    store_word_left_partial_op,
    store_word_right_partial_op
  } op_t;

  typedef enum logic [1:0] {
    st_idle,
    st_issue,
    st_wait
  } state_t;

endpackage

// ===== test/load_store_word_align_unit_tb_top.sv
// Self-checking bench: every op in every lane, then random ops.
// Assumes the lsu_mem_model memory model on the far side.
`timescale 1ns/1ps
module load_store_word_align_unit_tb_top;
  import lsu_align_pkg::*;
  logic ref_clk = 0, arst_n = 0, req_valid = 0, mode64 = 0, mem_req, mem_we, mem_ack;
  logic req_ready, wb_valid, done;
  op_t req_op = load_word_op;
  logic [63:0] base_value = 0, target_register = 0, mem_addr, wb_data;
  logic [15:0] offset = 0;
  logic [31:0] mem_rdata, mem_wdata, word = 0, seed = 32'h9;
  logic [3:0] mem_be, lat = 0;
  int miscompares = 0, checks_done = 0;
  bit hung = 0;
  load_store_word_align_unit uut (.ref_clk, .arst_n, .req_valid, .req_op, .mode64,
    .base_value, .offset, .target_register, .req_ready, .mem_req, .mem_we, .mem_addr,
    .mem_be, .mem_wdata, .mem_rdata, .mem_ack, .wb_valid, .wb_data, .done);
  lsu_mem_model mem (.ref_clk, .arst_n, .mem_req, .lat, .word, .mem_ack, .mem_rdata);
  initial forever #50 ref_clk = ~ref_clk;
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected load result
  function automatic logic [63:0] exp_ld(op_t op, logic [1:0] a, logic [31:0] m,
                                         logic [63:0] rt, logic md);
    logic [31:0] k, r;
    k = 32'hffffffff << 8 * (3 - a);
    r = m;
    if (op == load_word_left_partial_op) r = (m << 8 * (3 - a)) & k | rt[31:0] & ~k;
    k = 32'hffffffff >> 8 * a;
    if (op == load_word_right_partial_op) r = (m >> 8 * a) & k | rt[31:0] & ~k;
    return md ? {{32{r[31]}}, r} : {32'h0, r};
  endfunction
  // Expected lanes and lane-placed data of a store
  function automatic logic [35:0] exp_st(op_t op, logic [1:0] a, logic [63:0] rt);
    case (op)
      store_byte_op:      return {4'h1 << a, {4{rt[7:0]}}};
      store_halfword_op:  return {4'h3 << {a[1], 1'b0}, {2{rt[15:0]}}};
      store_word_op:      return {4'hf, rt[31:0]};
      store_word_left_partial_op: return {4'hf >> (3 - a), rt[31:0] >> 8 * (3 - a)};
      default:            return {4'hf << a, rt[31:0] << 8 * a};
    endcase
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // One operation, issued in the cycle ready is high
  task automatic run(input op_t op, input logic [1:0] a);
    logic [63:0] ad, rt, e;
    logic [35:0] s;
    logic [31:0] m;
    int n;
    rt = {rnd(), rnd()};
    base_value = {rnd(), rnd()};
    offset = rnd();
    base_value[1:0] = a - offset[1:0];
    ad = base_value + {{48{offset[15]}}, offset};
    req_op = op;
    target_register = rt;
    mode64 = rnd() % 2;
    word = rnd();
    lat = rnd() % 4;
    req_valid = 1;
    @(posedge ref_clk);
    #1 req_valid = 0;
    for (n = 0; n < 20 && !done; n++) begin
      @(posedge ref_clk);
      #1;
      if (mem_req) s = {mem_be, mem_wdata};
      if (mem_req) e = mem_addr;
    end
    if (!done) begin
      miscompares++;
      hung = 1;
      return;
    end
    chk(e, ad);
    if (op <= load_word_right_partial_op) begin
      chk(wb_valid, 1);
      chk(wb_data, exp_ld(op, a, word, rt, mode64));
    end else begin
      m = {{8{s[35]}}, {8{s[34]}}, {8{s[33]}}, {8{s[32]}}};
      chk({wb_valid, s[35:32], s[31:0] & m}, {1'b0, exp_st(op, a, rt) & {4'hf, m}});
    end
  endtask
  initial begin
    repeat (16) @(posedge ref_clk);
    #1 arst_n = 1;
    for (int i = 0; i < 32 && !hung; i++) run(op_t'(i / 4), i[1:0]);
    $display("corner test done");
    // Reset in mid-run: outputs return to their idle values
    arst_n = 0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk({req_ready, mem_req, mem_we, mem_be, wb_valid, done}, 9'h100);
    chk(wb_data | mem_addr | {32'h0, mem_wdata}, 64'h0);
    arst_n = 1;
    $display("reset test done");
    for (int i = 0; i < 300 && !hung; i++) run(op_t'(rnd() % 8), rnd());
    $display("random test done");
    test_done();
  end
endmodule

// ===== test/lsu_align_checker.sv
// Timing checks of the alignment unit at its top ports.
// Assumes bind to load_store_word_align_unit.
`timescale 1ns/1ps
module lsu_align_checker (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic        mode64,
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_ack,
  input wire logic [63:0] mem_addr,
  input wire logic [3:0]  mem_be,
  input wire logic [63:0] base_value,
  input wire logic [15:0] offset,
  input wire logic        done,
  input wire logic        wb_valid,
  input wire logic [63:0] wb_data
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Address the unit should form
  wire [63:0] sx = base_value + {{48{offset[15]}}, offset};
  logic mode_seen;
  // Mode latched with each taken request
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) mode_seen <= 1'b0;
    else if (req_valid && req_ready) mode_seen <= mode64;
  end
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_ack; mem_req && mem_ack; endsequence
  a_addr_form: assert property (s_take |-> ##2 mem_req && mem_addr == $past(sx, 2))
    else $error("address not base plus offset");
  a_busy_drop: assert property (s_take |=> !req_ready)
    else $error("ready stayed high");
  a_done_step: assert property (s_ack |=> done && !mem_req && req_ready)
    else $error("no completion after ack");
  a_load_wb: assert property (s_ack and !mem_we |=> wb_valid)
    else $error("load without writeback");
  a_store_nowb: assert property (s_ack and mem_we |=> !wb_valid)
    else $error("store wrote back");
  a_load_lanes: assert property (mem_req && !mem_we |-> mem_be == 4'hf)
    else $error("load lanes not all set");
  a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_be))
    else $error("request changed before ack");
  a_wb_upper: assert property (wb_valid |-> done &&
    wb_data[63:32] == (mode_seen ? {32{wb_data[31]}} : 32'h0))
    else $error("upper half not extended");
endmodule
bind load_store_word_align_unit lsu_align_checker u_chk (.ref_clk, .arst_n, .req_valid,
  .req_ready, .mem_req, .mem_we, .mem_ack, .mem_addr, .mem_be, .base_value, .offset,
  .mode64, .done, .wb_valid, .wb_data);

// ===== test/lsu_mem_model.sv
// Data memory model: answers each request with one ack pulse.
// Assumes the unit holds mem_req until the edge after mem_ack.
`timescale 1ns/1ps
module lsu_mem_model (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        mem_req,
  input  wire logic [3:0]  lat,
  input  wire logic [31:0] word,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  int cnt;
  // Ack after lat waiting cycles, then drop
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt = 0;
      mem_ack = 1'b0;
    end else begin
      #1;
      if (mem_ack || !mem_req) begin
        mem_ack = 1'b0;
        cnt = 0;
      end else if (cnt == lat) mem_ack = 1'b1;
      else cnt++;
    end
  end
  // Data valid only with ack, inverted otherwise
  assign mem_rdata = mem_ack ? word : ~word;
endmodule
